/* File: atr_counter.v */
// loadable 32-bit event counter used for the elapsed-time and startup counts
`timescale 1ns/10ps
`include "atr_regs.vh"
module atr_counter #(
  parameter WIDTH = 32
) (
  input  wire             clk_in,      // system clock
  input  wire             resetn_in,   // async reset, active low
  input  wire             load_in,     // restore from non-volatile copy
  input  wire [WIDTH-1:0] load_val_in, // restored value
  input  wire             inc_in,      // advance by one
  output wire [WIDTH-1:0] count_out    // current count
);
  reg  [WIDTH-1:0] count_r;
  wire [WIDTH-1:0] base;
  wire [WIDTH-1:0] count_nxt;

  // an increment in the restore cycle is kept, not lost
  assign base      = load_in ? load_val_in : count_r;
  assign count_nxt = base + {{(WIDTH-1){1'b0}}, inc_in};
  assign count_out = count_r;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_r <= `ATR_CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule // atr_counter

/* File: atr_master_model.sv */
// polling master standing in for the serial frame decoder
`timescale 1ns/10ps
module atr_master_model (
  input  wire        clk_in,        // system clock
  input  wire        busy_in,       // block busy
  input  wire        word_valid_in, // word offered
  input  wire [15:0] word_data_in,  // answer word
  input  wire        word_last_in,  // final word
  input  wire        exc_valid_in,  // exception pulse
  input  wire [7:0]  exc_code_in,   // exception code
  output reg         req_out,       // request strobe
  output reg  [7:0]  func_out,      // function code
  output reg  [15:0] addr_out,      // first address
  output reg  [7:0]  qty_out,       // register count
  output reg         ready_out      // word taken
);
  reg [15:0] words [0:31];
  reg [7:0]  exc_got;
  integer    got;
  initial begin
    req_out = 1'b0;
    func_out = 8'h00;
    addr_out = 16'h0000;
    qty_out = 8'h00;
    ready_out = 1'b0;
  end
  // called just after an edge; a stalling master is ready only every other cycle
  task xfer(input [7:0] f, input [15:0] a, input [7:0] q, input stall);
    reg     done;
    integer w;
    begin
      // a new request only once the previous answer has ended
      while (busy_in) begin
        @(posedge clk_in);
        #1;
      end
      got = 0;
      exc_got = 8'hFF;
      done = 1'b0;
      w = 0;
      req_out = 1'b1; // pairs go out in one request
      func_out = f;
      addr_out = a;
      qty_out = q;
      ready_out = !stall;
      @(posedge clk_in);
      #1 req_out = 1'b0;
      // released lines carry no stale copy of the request
      func_out = ~f;
      addr_out = ~a;
      qty_out = ~q;
      // a hang is caught by the bench's cycle ceiling
      while (!done) begin
        @(posedge clk_in);
        if (exc_valid_in) begin
          exc_got = exc_code_in;
          done = 1'b1;
        end else if (word_valid_in && ready_out) begin
          words[got] = word_data_in;
          got = got + 1;
          done = word_last_in;
        end
        #1 w = w + 1;
        ready_out = !stall || w[0];
      end
      ready_out = 1'b0;
      @(posedge clk_in);
      #1;
    end
  endtask
endmodule // atr_master_model

/* File: atr_regs.vh */
// constants for the actuator telemetry holding-register block
// What this block does
// RL1: 32-bit powered-time counter at 0x000E/0x000F
// RL2: firmware revision selects hours or minutes unit
// RL3: open-time counter at 0x0010, counts at 100%
// RL4: closed-time counter at 0x0012, counts at 0%
// RL5: startup counter at 0x0014, one per startup
// RL6: pairs read in one request, one snapshot
// RL7: read-only 32-bit serial number at 0x0016
// RL8: scaled analog, 0-200 current, 0-50 voltage
// RL9: version word: whole high byte, fraction low
// RL10: fixed identification words at 0x0019, 0x001A
// RL11: sticky non-volatile fault history at 0x001C
// RL12: history low byte collects live fault flag bits 7:0
// RL13: reserved words 0x001D, 0x001E read zero
// RL14: only function 0x03 reaches these registers
// RL15: low byte faults block actuation; high status
// RL16: prescaler tick per unit drives time counters
`ifndef ATR_REGS_VH
`define ATR_REGS_VH
`define ATR_FUNC_RD_HOLD  8'h03
`define ATR_EXC_ILL_FUNC  8'h01
`define ATR_EXC_ILL_ADDR  8'h02
`define ATR_EXC_ILL_VAL   8'h03
`define ATR_QTY_MAX       8'h7D
`define ATR_A_POWERED_LO  16'h000E
`define ATR_A_POWERED_HI  16'h000F
`define ATR_A_OPEN_LO     16'h0010
`define ATR_A_OPEN_HI     16'h0011
`define ATR_A_CLOSED_LO   16'h0012
`define ATR_A_CLOSED_HI   16'h0013
`define ATR_A_START_LO    16'h0014
`define ATR_A_START_HI    16'h0015
`define ATR_A_SERIAL_LO   16'h0016
`define ATR_A_SERIAL_HI   16'h0017
`define ATR_A_ANALOG      16'h0018
`define ATR_A_PROJ_ID     16'h0019
`define ATR_A_DOC_ID      16'h001A
`define ATR_A_VERSION     16'h001B
`define ATR_A_FAULT_HIST  16'h001C
`define ATR_A_SPARE0      16'h001D
`define ATR_A_SPARE1      16'h001E
`define ATR_A_FIRST       16'h000E
`define ATR_A_LAST        16'h001E
`define ATR_ANA_MAX_CUR   16'h00C8
`define ATR_ANA_MAX_VOLT  16'h0032
`define ATR_FAULT_MSB     7
`define ATR_FAULT_LSB     0
`define ATR_CNT_RST       32'h00000000
`define ATR_HIST_RST      16'h0000
`define ATR_WORD_ZERO     16'h0000
`define ATR_CLK_HZ        10000000
`define ATR_MINUTE_S      60
`define ATR_HOUR_S        3600
`define ATR_REV_HOURS     8'h13
`endif

/* File: atr_telemetry.v */
// read-only telemetry holding registers of the valve actuator
`timescale 1ns/10ps
`include "atr_regs.vh"
module atr_telemetry #(
  parameter [7:0]  FW_MAJOR    = 8'h04,   // whole part of firmware version
  parameter [7:0]  FW_MINOR    = 8'h21,   // fraction part of version
  parameter [15:0] PROJ_ID     = 16'h0A5A, // arbitrary value
  parameter [15:0] DOC_ID      = 16'h1C3C, // arbitrary value
  parameter [35:0] UNIT_CYCLES =
    (FW_MINOR == `ATR_REV_HOURS) ?
      (36'd`ATR_HOUR_S * 36'd`ATR_CLK_HZ) :
      (36'd`ATR_MINUTE_S * 36'd`ATR_CLK_HZ)
) (
  input  wire        clk_in,           // system clock, 10 MHz
  input  wire        resetn_in,        // async reset, active low
  input  wire        req_in,           // request pulse from frame decoder
  input  wire [7:0]  req_func_in,      // function code of request
  input  wire [15:0] req_addr_in,      // first register address
  input  wire [7:0]  req_qty_in,       // number of registers
  output wire        busy_out,         // request in progress
  output wire        word_valid_out,   // answer word available
  input  wire        word_ready_in,    // answer word taken
  output wire [15:0] word_data_out,    // answer word
  output wire        word_last_out,    // final word of answer
  output wire        exc_valid_out,    // exception answer pulse
  output wire [7:0]  exc_code_out,     // exception code
  input  wire        pos_open_in,      // valve at fully open
  input  wire        pos_closed_in,    // valve at fully closed
  input  wire        startup_done_in,  // startup completed pulse
  input  wire [15:0] analog_in,        // scaled analog sample
  input  wire        analog_current_in,// 1 current input, 0 voltage
  input  wire [31:0] serial_in,        // unit serial number
  input  wire [15:0] fault_live_in,    // live diagnostic flags
  input  wire        nv_load_in,       // restore pulse from storage
  input  wire [31:0] nv_powered_in,    // stored powered time
  input  wire [31:0] nv_open_in,       // stored open time
  input  wire [31:0] nv_closed_in,     // stored closed time
  input  wire [31:0] nv_startup_in,    // stored startup count
  input  wire [15:0] nv_fault_in,      // stored fault history
  output reg  [15:0] nv_fault_out,     // history to store
  output reg         nv_save_out,      // history changed pulse
  output wire [31:0] powered_out,      // live powered time
  output wire [31:0] open_out,         // live open time
  output wire [31:0] closed_out,       // live closed time
  output wire [31:0] startup_out,      // live startup count
  output reg         fault_block_out   // actuation blocked by fault
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LOAD = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;
  localparam [1:0] ST_EXC  = 2'b11;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [15:0] addr_r;
  reg  [7:0]  left_r;
  reg  [7:0]  exc_r;
  reg  [7:0]  exc_nxt;
  reg  [15:0] data_r;
  reg  [35:0] presc_r;
  reg         tick_r;
  reg  [15:0] hist_r;
  reg  [15:0] analog_r;
  reg  [31:0] snap_pow_r;
  reg  [31:0] snap_open_r;
  reg  [31:0] snap_closed_r;
  reg  [31:0] snap_start_r;
  reg  [31:0] snap_serial_r;
  reg  [15:0] snap_analog_r;
  reg  [15:0] snap_hist_r;
  reg  [15:0] word;
  reg  [15:0] ana_max;
  wire [15:0] sel_addr;
  wire [16:0] end_addr;
  wire        accept;
  wire        take;
  wire [15:0] hist_nxt;

  assign accept = (state_r == ST_IDLE) && req_in;
  assign take   = (state_r == ST_SEND) && word_ready_in;

  // unit prescaler; one tick per hour or minute by revision
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      presc_r <= 36'h000000000;
      tick_r  <= 1'b0;
    end else if (presc_r == UNIT_CYCLES - 36'h000000001) begin // [RL2] [RL16]
      presc_r <= 36'h000000000;
      tick_r  <= 1'b1;
    end else begin
      presc_r <= presc_r + 36'h000000001;
      tick_r  <= 1'b0;
    end
  end

  atr_counter #(.WIDTH(32)) u_powered (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .load_in     (nv_load_in),
    .load_val_in (nv_powered_in),
    .inc_in      (tick_r),                 // [RL1] [RL16]
    .count_out   (powered_out)
  );

  atr_counter #(.WIDTH(32)) u_open (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .load_in     (nv_load_in),
    .load_val_in (nv_open_in),
    .inc_in      (tick_r & pos_open_in),   // [RL3] [RL16]
    .count_out   (open_out)
  );

  atr_counter #(.WIDTH(32)) u_closed (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .load_in     (nv_load_in),
    .load_val_in (nv_closed_in),
    .inc_in      (tick_r & pos_closed_in), // [RL4] [RL16]
    .count_out   (closed_out)
  );

  atr_counter #(.WIDTH(32)) u_startup (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .load_in     (nv_load_in),
    .load_val_in (nv_startup_in),
    .inc_in      (startup_done_in),        // [RL5]
    .count_out   (startup_out)
  );

  // only the fault byte is sticky; status bits keep their live meaning
  assign hist_nxt = (nv_load_in ? nv_fault_in : hist_r) |
                    {8'h00, fault_live_in[`ATR_FAULT_MSB:`ATR_FAULT_LSB]};
                                                    // [RL11] [RL12]

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hist_r          <= `ATR_HIST_RST;
      nv_fault_out    <= `ATR_HIST_RST;
      nv_save_out     <= 1'b0;
      fault_block_out <= 1'b0;
    end else begin
      hist_r          <= hist_nxt;                   // [RL11]
      nv_fault_out    <= hist_nxt;
      // a restore is not a change, so no write-back then
      nv_save_out     <= !nv_load_in && (hist_nxt != hist_r); // [RL11]
      fault_block_out <=
        |fault_live_in[`ATR_FAULT_MSB:`ATR_FAULT_LSB]; // [RL15]
    end
  end

  // analog value clamped to the span of the selected input type
  always @* begin
    ana_max = analog_current_in ? `ATR_ANA_MAX_CUR : `ATR_ANA_MAX_VOLT;
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      analog_r <= `ATR_WORD_ZERO;
    end else if (analog_in > ana_max) begin
      analog_r <= ana_max;                           // [RL8]
    end else begin
      analog_r <= analog_in;                         // [RL8]
    end
  end

  // the whole map is frozen on acceptance, so both halves of a pair
  // and every word of one answer come from the same instant
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      snap_pow_r    <= `ATR_CNT_RST;
      snap_open_r   <= `ATR_CNT_RST;
      snap_closed_r <= `ATR_CNT_RST;
      snap_start_r  <= `ATR_CNT_RST;
      snap_serial_r <= `ATR_CNT_RST;
      snap_analog_r <= `ATR_WORD_ZERO;
      snap_hist_r   <= `ATR_HIST_RST;
    end else if (accept) begin                       // [RL6]
      snap_pow_r    <= powered_out;
      snap_open_r   <= open_out;
      snap_closed_r <= closed_out;
      snap_start_r  <= startup_out;
      snap_serial_r <= serial_in;                    // [RL7]
      snap_analog_r <= analog_r;
      snap_hist_r   <= hist_r;
    end
  end

  // the load cycle fetches the first word, sending fetches the next
  assign sel_addr = (state_r == ST_LOAD) ? addr_r : addr_r + 16'h0001;

  always @* begin
    case (sel_addr)
      `ATR_A_POWERED_LO: word = snap_pow_r[31:16];    // [RL1]
      `ATR_A_POWERED_HI: word = snap_pow_r[15:0];
      `ATR_A_OPEN_LO:    word = snap_open_r[31:16];   // [RL3]
      `ATR_A_OPEN_HI:    word = snap_open_r[15:0];
      `ATR_A_CLOSED_LO:  word = snap_closed_r[31:16]; // [RL4]
      `ATR_A_CLOSED_HI:  word = snap_closed_r[15:0];
      `ATR_A_START_LO:   word = snap_start_r[31:16];  // [RL5]
      `ATR_A_START_HI:   word = snap_start_r[15:0];
      `ATR_A_SERIAL_LO:  word = snap_serial_r[31:16]; // [RL7]
      `ATR_A_SERIAL_HI:  word = snap_serial_r[15:0];
      `ATR_A_ANALOG:     word = snap_analog_r;        // [RL8]
      `ATR_A_PROJ_ID:    word = PROJ_ID;              // [RL10]
      `ATR_A_DOC_ID:     word = DOC_ID;               // [RL10]
      `ATR_A_VERSION:    word = {FW_MAJOR, FW_MINOR}; // [RL9]
      `ATR_A_FAULT_HIST: word = snap_hist_r;          // [RL11] [RL12]
      `ATR_A_SPARE0:     word = `ATR_WORD_ZERO;       // [RL13]
      `ATR_A_SPARE1:     word = `ATR_WORD_ZERO;       // [RL13]
      default:           word = `ATR_WORD_ZERO;
    endcase
  end

  // last address of the request, one bit wider to catch wrap
  assign end_addr = {1'b0, req_addr_in} + {9'h000, req_qty_in} -
                    17'h00001;

  // request check: function first, then quantity, then range
  always @* begin
    exc_nxt = 8'h00;
    if (req_func_in != `ATR_FUNC_RD_HOLD) begin
      exc_nxt = `ATR_EXC_ILL_FUNC;                   // [RL14]
    end else if (req_qty_in == 8'h00 || req_qty_in > `ATR_QTY_MAX) begin
      exc_nxt = `ATR_EXC_ILL_VAL;
    end else if (req_addr_in < `ATR_A_FIRST ||
                 end_addr > {1'b0, `ATR_A_LAST}) begin
      exc_nxt = `ATR_EXC_ILL_ADDR;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (req_in) begin
          state_nxt = (exc_nxt != 8'h00) ? ST_EXC : ST_LOAD;
        end
      end
      ST_LOAD: begin
        state_nxt = ST_SEND;
      end
      ST_SEND: begin
        if (word_ready_in && left_r == 8'h01) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_EXC: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
      addr_r  <= 16'h0000;
      left_r  <= 8'h00;
      exc_r   <= 8'h00;
      data_r  <= `ATR_WORD_ZERO;
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        addr_r <= req_addr_in;
        left_r <= req_qty_in;
        exc_r  <= exc_nxt;
      end else if (state_r == ST_LOAD) begin
        data_r <= word;
      end else if (take) begin
        addr_r <= addr_r + 16'h0001;
        left_r <= left_r - 8'h01;
        data_r <= word;
      end
    end
  end

  assign busy_out       = (state_r != ST_IDLE);
  assign word_valid_out = (state_r == ST_SEND);
  assign word_data_out  = data_r;
  assign word_last_out  = (state_r == ST_SEND) && (left_r == 8'h01);
  assign exc_valid_out  = (state_r == ST_EXC);
  assign exc_code_out   = exc_r;
endmodule // atr_telemetry

/* File: atr_telemetry_checker.sv */
// concurrent checks on the telemetry register block ports
`timescale 1ns/10ps
module atr_telemetry_checker (
  input wire        clk_in,          // system clock
  input wire        resetn_in,       // async reset, active low
  input wire        req_in,          // request strobe
  input wire [7:0]  req_func_in,     // function code
  input wire [15:0] req_addr_in,     // first address
  input wire [7:0]  req_qty_in,      // register count
  input wire        busy_out,        // request in progress
  input wire        word_valid_out,  // word offered
  input wire        word_ready_in,   // word taken
  input wire [15:0] word_data_out,   // answer word
  input wire        word_last_out,   // final word
  input wire        exc_valid_out,   // exception pulse
  input wire [7:0]  exc_code_out,    // exception code
  input wire        pos_open_in,     // valve fully open
  input wire        pos_closed_in,   // valve fully closed
  input wire        startup_done_in, // startup pulse
  input wire [15:0] fault_live_in,   // live flags
  input wire        nv_load_in,      // restore pulse
  input wire [15:0] nv_fault_out,    // history copy
  input wire [31:0] powered_out,     // powered time
  input wire [31:0] open_out,        // open time
  input wire [31:0] closed_out,      // closed time
  input wire [31:0] startup_out,     // startup count
  input wire        fault_block_out  // actuation blocked
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire        take = req_in && !busy_out;
  wire [16:0] end_a = {1'b0, req_addr_in} + {9'h000, req_qty_in} - 17'h1;
  wire        good = take && req_func_in == 8'h03 && req_qty_in != 8'h00 &&
                     req_qty_in <= 8'h7D && req_addr_in >= 16'h000E &&
                     end_a <= 17'h0001E;
  sequence s_load;
    busy_out && !word_valid_out && !exc_valid_out;
  endsequence
  sequence s_offer;
    busy_out && word_valid_out;
  endsequence
  chk_read_walk: assert property (good |=> s_load ##1 s_offer)
    else $error("read answer out of step");
  chk_word_hold: assert property (word_valid_out && !word_ready_in |=>
    word_valid_out && $stable(word_data_out))
    else $error("offered word dropped or changed");
  chk_last_done: assert property (word_valid_out && word_ready_in &&
    word_last_out |=> !busy_out && !word_valid_out)
    else $error("answer did not end after last word");
  chk_write_refused: assert property (take && req_func_in != 8'h03 |=>
    exc_valid_out && exc_code_out == 8'h01)
    else $error("wrong function not refused");
  chk_block_flag: assert property (1'b1 |=>
    fault_block_out == |$past(fault_live_in[7:0]))
    else $error("block flag not from low flag byte");
  chk_hist_sticky: assert property (!nv_load_in && !$past(nv_load_in) |=>
    (nv_fault_out & $past(nv_fault_out)) == $past(nv_fault_out))
    else $error("history lost a bit");
  chk_start_inc: assert property (startup_done_in && !nv_load_in |=>
    startup_out == $past(startup_out) + 32'h1)
    else $error("startup count did not step");
  chk_open_hold: assert property (!pos_open_in && !nv_load_in |=>
    $stable(open_out))
    else $error("open time moved while not open");
  chk_closed_hold: assert property (!pos_closed_in && !nv_load_in |=>
    $stable(closed_out))
    else $error("closed time moved while not closed");
  chk_power_step: assert property (!nv_load_in |=>
    powered_out - $past(powered_out) <= 32'h1)
    else $error("powered time jumped");
endmodule // atr_telemetry_checker
bind atr_telemetry atr_telemetry_checker chk_u (.*);

/* File: testbench.sv */
// self-checking bench for the telemetry register block
`timescale 1ns/10ps
module testbench;
  reg         clk_in, resetn_in, pos_open_in, pos_closed_in, nv_load_in;
  reg         startup_done_in, analog_current_in;
  reg  [15:0] analog_in, fault_live_in, nv_fault_in, ae;
  reg  [31:0] serial_in, nv_powered_in, nv_open_in, nv_closed_in;
  reg  [31:0] nv_startup_in, p0, o0, c0;
  wire        req_in, busy_out, word_valid_out, word_ready_in, word_last_out;
  wire        exc_valid_out, nv_save_out, fault_block_out;
  wire [7:0]  req_func_in, req_qty_in, exc_code_out;
  wire [15:0] req_addr_in, word_data_out, nv_fault_out;
  wire [31:0] powered_out, open_out, closed_out, startup_out;
  integer     bad_count, checks_done, cyc, i;
  reg  [39:0] xt [0:5];
  reg  [32:0] at [0:3];
  reg [207:0] ev;
  // bench identity words differ from the defaults so the parameters are seen
  atr_telemetry #(.UNIT_CYCLES(36'd20), .PROJ_ID(16'h5A0F),
    .DOC_ID(16'h3C0F)) dut_u (.*);
  atr_master_model mst_u (.clk_in(clk_in), .busy_in(busy_out),
    .word_valid_in(word_valid_out), .word_data_in(word_data_out),
    .word_last_in(word_last_out), .exc_valid_in(exc_valid_out),
    .exc_code_in(exc_code_out), .req_out(req_in), .func_out(req_func_in),
    .addr_out(req_addr_in), .qty_out(req_qty_in), .ready_out(word_ready_in));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (bad_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end
  initial begin
    bad_count = 0; checks_done = 0; cyc = 0; resetn_in = 1'b0;
    pos_open_in = 1'b1; pos_closed_in = 1'b0; startup_done_in = 1'b0;
    nv_load_in = 1'b0; analog_current_in = 1'b1; analog_in = 16'h0100;
    fault_live_in = 16'h0000; nv_fault_in = 16'h8001;
    serial_in = 32'h12345678; nv_powered_in = 32'h0001FFFF;
    nv_open_in = 32'h0000FFFF; nv_closed_in = 32'h00A0B0C0;
    nv_startup_in = 32'h00000007;
    xt[0] = 40'h06_0016_01_01; xt[1] = 40'h10_0016_02_01;
    xt[2] = 40'h03_000E_00_03; xt[3] = 40'h03_000E_7E_03;
    xt[4] = 40'h03_000D_01_02; xt[5] = 40'h03_001E_02_02;
    at[0] = 33'h0_0031_0031; at[1] = 33'h0_0033_0032;
    at[2] = 33'h1_00C8_00C8; at[3] = 33'h1_FFFF_00C8;
    ev = 208'h00A0_B0C0_0000_000A_1234_5678_00C8_5A0F_3C0F_0421_8011_0000_0000;
    tick(6);
    resetn_in = 1'b1;
    nv_load_in = 1'b1;
    tick(1);
    nv_load_in = 1'b0;
    chk({nv_save_out, nv_fault_out}, 32'h08001);
    fault_live_in = 16'h0F10;
    tick(1);
    fault_live_in = 16'h0000;
    chk({nv_save_out, nv_fault_out}, 32'h18011);
    for (i = 0; i < 3; i = i + 1) begin
      startup_done_in = 1'b1; tick(1); startup_done_in = 1'b0; tick(1);
    end
    // whole map, stalling; the first unit tick carries powered time
    // between the fetch of its two halves, so only a snapshot reads 1FFFF
    tick(11);
    mst_u.xfer(8'h03, 16'h000E, 8'h11, 1'b1);
    chk(mst_u.got, 32'd17);
    chk({mst_u.words[0], mst_u.words[1]}, 32'h0001FFFF);
    chk({mst_u.words[2], mst_u.words[3]}, 32'h0000FFFF);
    for (i = 4; i < 17; i = i + 1)
      chk(mst_u.words[i], ev[(16 - i) * 16 +: 16]);
    mst_u.xfer(8'h03, 16'h0013, 8'h02, 1'b0);
    chk({mst_u.words[0], mst_u.words[1]}, 32'hB0C00000);
    pos_open_in = 1'b0;
    pos_closed_in = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      {analog_current_in, analog_in, ae} = at[i];
      tick(2);
      mst_u.xfer(8'h03, 16'h0018, 8'h01, 1'b0);
      chk(mst_u.words[0], ae);
    end
    for (i = 0; i < 6; i = i + 1) begin
      mst_u.xfer(xt[i][39:32], xt[i][31:16], xt[i][15:8], 1'b0);
      chk(mst_u.exc_got, xt[i][7:0]);
    end
    // power loss: the store hands back what it last kept
    resetn_in = 1'b0; tick(2); resetn_in = 1'b1;
    nv_fault_in = 16'h8011;
    nv_load_in = 1'b1; tick(1); nv_load_in = 1'b0; tick(1);
    mst_u.xfer(8'h03, 16'h001C, 8'h03, 1'b0);
    chk({mst_u.words[0], mst_u.words[1]}, 32'h80110000);
    chk(mst_u.words[2], 32'h0);
    // any window of one counting unit holds exactly one tick
    p0 = powered_out;
    o0 = open_out;
    c0 = closed_out;
    tick(20);
    chk(powered_out, p0 + 32'h1);
    chk(open_out, o0);
    chk(closed_out, c0 + 32'h1);
    wrap_up;
  end
endmodule // testbench
